// File: logic/emb_external_bus.sv
// emb_external_bus: external program/data memory bus sequencer with strobes
// assumes one request source on the core side and asynchronous static memories outside
//
// What this block does
// RQ1 - drive a 19-bit address bus shared by data RAM and program memory
// RQ2 - program memory select acts as read strobe for program fetches
// RQ3 - high-byte write strobe asserted for high-byte and full word writes
// RQ4 - low-byte write strobe asserted for low-byte and full word writes
// RQ5 - dedicated data read strobe for data memory, distinct from program strobe
// RQ6 - write and read strobes are two-way pins, driven normally, input only in test
// RQ7 - lowest address line is bit 1; byte strobes choose the byte
// RQ8 - data moves over one shared two-way 16-bit data bus
// RQ9 - address bus reaches bit 19 as its top line
// RQ10 - program select never active together with data read or write strobes
`timescale 1ns/100ps
module emb_external_bus
  import emb_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       srst,
  // core side request
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  emb_kind_t                       req_kind,
  input  wire logic [EMB_BYTE_ADDR_W-1:0] req_addr,
  input  wire logic [EMB_DATA_W-1:0]      req_wdata,
  input  wire logic [EMB_BE_W-1:0]        req_be,
  output logic                            resp_valid,
  output logic [EMB_DATA_W-1:0]           resp_rdata,
  // test mode releases the two-way strobes
  input  wire logic                       test_mode,
  output logic [2:0]                      test_strobe_seen,
  // memory side pins
  output logic [EMB_ADDR_MSB:EMB_ADDR_LSB] mem_addr,
  output logic                            program_memory_select_n,
  output logic                            data_read_strobe_n_o,
  output logic                            data_read_strobe_n_oe,
  input  wire logic                       data_read_strobe_n_i,
  output logic                            high_byte_write_strobe_n_o,
  output logic                            high_byte_write_strobe_n_oe,
  input  wire logic                       high_byte_write_strobe_n_i,
  output logic                            low_byte_write_strobe_n_o,
  output logic                            low_byte_write_strobe_n_oe,
  input  wire logic                       low_byte_write_strobe_n_i,
  output logic [EMB_DATA_W-1:0]           mem_data_o,
  output logic                            mem_data_oe,
  input  wire logic [EMB_DATA_W-1:0]      mem_data_i
);

  typedef enum logic [1:0] {
    EMB_ST_IDLE,
    EMB_ST_SETUP,
    EMB_ST_STROBE,
    EMB_ST_HOLD
  } emb_state_t;

  emb_state_t               state_reg;
  emb_state_t               state_next;
  emb_kind_t                kind_reg;
  logic [EMB_BE_W-1:0]      be_reg;
  logic [EMB_ADDR_W-1:0]    addr_reg;
  logic [EMB_DATA_W-1:0]    wdata_reg;
  logic [EMB_CNT_W-1:0]     cnt_reg;
  logic                     pms_n_reg;
  logic                     rd_n_reg;
  logic                     wrh_n_reg;
  logic                     wrl_n_reg;
  logic                     data_oe_reg;
  logic [EMB_DATA_W-1:0]    rdata_reg;
  logic                     resp_valid_reg;
  logic [2:0]               test_seen_reg;
  logic                     take;
  logic                     strobe_done;
  logic                     pm_sel;
  logic                     rd_sel;
  logic                     wrh_sel;
  logic                     wrl_sel;

  // request acceptance: one access at a time, none in test mode
  // test mode blocks new accesses, so only an access taken before test mode rose can still strobe while the pins are released
  assign req_ready   = (state_reg == EMB_ST_IDLE) && !test_mode;
  assign take        = req_valid && req_ready;
  assign strobe_done = (state_reg == EMB_ST_STROBE) && (cnt_reg == EMB_STROBE_LAST);

  // strobe selection for the latched access
  emb_strobe_decode u_decode (
    .kind    (kind_reg),
    .be      (be_reg),
    .pm_sel  (pm_sel),
    .rd_sel  (rd_sel),
    .wrh_sel (wrh_sel),
    .wrl_sel (wrl_sel)
  );

  // next state: setup, strobe, hold around every access
  // the length is fixed; a core that waits on req_ready can never shorten a strobe,
  // and the setup cycle lets the address settle before any memory is selected
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EMB_ST_IDLE:   if (take) state_next = EMB_ST_SETUP;
      EMB_ST_SETUP:  state_next = EMB_ST_STROBE;
      EMB_ST_STROBE: if (strobe_done) state_next = EMB_ST_HOLD;
      EMB_ST_HOLD:   state_next = EMB_ST_IDLE;
      default:       state_next = EMB_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= EMB_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // access latch: address, kind, lanes and write data
  always_ff @(posedge clk) begin
    if (srst) begin
      kind_reg  <= EMB_KIND_NONE;
      be_reg    <= EMB_BE_RST;
      addr_reg  <= EMB_ADDR_RST;
      wdata_reg <= EMB_DATA_RST;
    end else if (take) begin
      kind_reg  <= req_kind;
      be_reg    <= req_be;
      // RQ7 drop address bit 0
      addr_reg  <= req_addr[EMB_ADDR_MSB:EMB_ADDR_LSB];
      wdata_reg <= req_wdata;
    end
  end

  // strobe width counter
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= EMB_CNT_ZERO;
    end else if (state_reg == EMB_ST_STROBE && !strobe_done) begin
      cnt_reg <= cnt_reg + EMB_CNT_ONE;
    end else begin
      cnt_reg <= EMB_CNT_ZERO;
    end
  end

  // strobes: asserted low only for the strobe phase
  always_ff @(posedge clk) begin
    if (srst) begin
      pms_n_reg <= 1'b1;
      rd_n_reg  <= 1'b1;
      wrh_n_reg <= 1'b1;
      wrl_n_reg <= 1'b1;
    end else if (state_next == EMB_ST_STROBE) begin
      // RQ10 exclusive strobe families
      pms_n_reg <= !pm_sel;
      rd_n_reg  <= !rd_sel;
      wrh_n_reg <= !wrh_sel;
      wrl_n_reg <= !wrl_sel;
    end else begin
      pms_n_reg <= 1'b1;
      rd_n_reg  <= 1'b1;
      wrh_n_reg <= 1'b1;
      wrl_n_reg <= 1'b1;
    end
  end

  // data bus drive for writes through strobe and hold
  // drive starts two cycles after the take, with the strobes, so the bus is not fought while a memory
  // that was read last is still letting go of it; it ends one cycle after the strobes
  always_ff @(posedge clk) begin
    if (srst) begin
      data_oe_reg <= 1'b0;
    end else begin
      // RQ8 drive shared bus
      data_oe_reg <= (kind_reg == EMB_KIND_WRITE) && (state_next != EMB_ST_IDLE) && (state_reg != EMB_ST_IDLE);
    end
  end

  // read data capture at the end of the strobe, completion pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg      <= EMB_DATA_RST;
      resp_valid_reg <= 1'b0;
    end else begin
      resp_valid_reg <= strobe_done;
      if (strobe_done && (kind_reg == EMB_KIND_FETCH || kind_reg == EMB_KIND_READ)) begin
        // RQ8 sample shared bus
        rdata_reg <= mem_data_i;
      end
    end
  end

  // test observation of the released strobe pins
  // outside test mode the last pattern seen stays readable
  always_ff @(posedge clk) begin
    if (srst) begin
      test_seen_reg <= 3'h0;
    end else if (test_mode) begin
      test_seen_reg <= {high_byte_write_strobe_n_i, low_byte_write_strobe_n_i, data_read_strobe_n_i};
    end
  end

  // pin outputs
  // RQ1 address bus out
  // RQ9 top line bit 19
  assign mem_addr                    = addr_reg;
  // RQ2 program read strobe
  assign program_memory_select_n     = pms_n_reg;
  // RQ6 strobes driven unless testing
  assign data_read_strobe_n_o        = rd_n_reg;
  assign data_read_strobe_n_oe       = !test_mode;
  assign high_byte_write_strobe_n_o  = wrh_n_reg;
  assign high_byte_write_strobe_n_oe = !test_mode;
  assign low_byte_write_strobe_n_o   = wrl_n_reg;
  assign low_byte_write_strobe_n_oe  = !test_mode;
  assign mem_data_o                  = wdata_reg;
  assign mem_data_oe                 = data_oe_reg;
  assign resp_valid                  = resp_valid_reg;
  assign resp_rdata                  = rdata_reg;
  assign test_strobe_seen            = test_seen_reg;

endmodule : emb_external_bus

// File: logic/emb_pkg.sv
// emb_pkg: shared constants and types for the external memory bus strobe block
// assumes a single 20 MHz system clock and synchronous, active-high reset
package emb_pkg;

  // bus widths
  localparam int unsigned EMB_ADDR_MSB   = 19;              // top address line
  localparam int unsigned EMB_ADDR_LSB   = 1;               // lowest address line driven
  localparam int unsigned EMB_ADDR_W     = EMB_ADDR_MSB - EMB_ADDR_LSB + 1;
  localparam int unsigned EMB_BYTE_ADDR_W = EMB_ADDR_MSB + 1;
  localparam int unsigned EMB_DATA_W     = 16;
  localparam int unsigned EMB_BE_W       = 2;

  // byte enable lanes
  localparam int unsigned EMB_BE_LOW     = 0;
  localparam int unsigned EMB_BE_HIGH    = 1;

  // timing: clock period and strobe width
  localparam int unsigned EMB_CLK_PERIOD_NS = 50;
  localparam int unsigned EMB_STROBE_NS     = 100;          // least strobe width
  localparam int unsigned EMB_STROBE_CYC    =
    (EMB_STROBE_NS + EMB_CLK_PERIOD_NS - 1) / EMB_CLK_PERIOD_NS;
  localparam int unsigned EMB_CNT_W         = 4;
  localparam logic [EMB_CNT_W-1:0] EMB_STROBE_LAST =
    EMB_CNT_W'(EMB_STROBE_CYC - 1);
  localparam logic [EMB_CNT_W-1:0] EMB_CNT_ZERO = 4'h0;
  localparam logic [EMB_CNT_W-1:0] EMB_CNT_ONE  = 4'h1;

  // reset values
  localparam logic [EMB_ADDR_W-1:0] EMB_ADDR_RST = 19'h0_0000;
  localparam logic [EMB_DATA_W-1:0] EMB_DATA_RST = 16'h0000;
  localparam logic [EMB_BE_W-1:0]   EMB_BE_RST   = 2'h0;

  // access kinds requested by the core side
  typedef enum logic [1:0] {
    EMB_KIND_FETCH,   // program memory read
    EMB_KIND_READ,    // data memory read
    EMB_KIND_WRITE,   // data memory write, lanes from byte enables
    EMB_KIND_NONE
  } emb_kind_t;

endpackage : emb_pkg

// File: logic/emb_strobe_decode.sv
// emb_strobe_decode: maps an access kind and byte enables onto the four strobe selects
// assumes the caller registers the results before they reach the pins
`timescale 1ns/100ps
module emb_strobe_decode
  import emb_pkg::*;
(
  input  emb_kind_t           kind,
  input  wire logic [EMB_BE_W-1:0] be,
  output logic                pm_sel,
  output logic                rd_sel,
  output logic                wrh_sel,
  output logic                wrl_sel
);

  // one strobe family per kind, never two at once
  always_comb begin
    pm_sel  = 1'b0;
    rd_sel  = 1'b0;
    wrh_sel = 1'b0;
    wrl_sel = 1'b0;
    case (kind)
      // RQ2 program fetch strobe
      EMB_KIND_FETCH: pm_sel = 1'b1;
      // RQ5 separate data read
      EMB_KIND_READ:  rd_sel = 1'b1;
      EMB_KIND_WRITE: begin
        // RQ3 high lane write
        wrh_sel = be[EMB_BE_HIGH];
        // RQ4 low lane write
        wrl_sel = be[EMB_BE_LOW];
      end
      default: pm_sel = 1'b0;
    endcase
  end

endmodule : emb_strobe_decode

// File: test/emb_external_bus_checker.sv
// emb_external_bus_checker: strobe timing and exclusivity on the bus block's ports
// assumes a bind onto emb_external_bus, one clk domain, srst active high
`timescale 1ns/100ps
module emb_external_bus_checker
  import emb_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        srst,
  input wire logic                        req_valid,
  input wire logic                        req_ready,
  input emb_kind_t                        req_kind,
  input wire logic [EMB_BYTE_ADDR_W-1:0]  req_addr,
  input wire logic [EMB_BE_W-1:0]         req_be,
  input wire logic                        resp_valid,
  input wire logic                        test_mode,
  input wire logic [EMB_ADDR_MSB:EMB_ADDR_LSB] mem_addr,
  input wire logic                        program_memory_select_n,
  input wire logic                        data_read_strobe_n_o,
  input wire logic                        data_read_strobe_n_oe,
  input wire logic                        high_byte_write_strobe_n_o,
  input wire logic                        high_byte_write_strobe_n_oe,
  input wire logic                        low_byte_write_strobe_n_o,
  input wire logic                        low_byte_write_strobe_n_oe,
  input wire logic                        mem_data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // request taken and its kind
  wire logic tk = req_valid && req_ready;
  wire logic wt = tk && (req_kind == EMB_KIND_WRITE);
  a_addr_follows: assert property (tk |=> mem_addr == ($past(req_addr) >> 1))
    else $error("address bus wrong");
  a_answer_time: assert property (tk |=> !resp_valid [*3] ##1 resp_valid)
    else $error("answer late or early");
  a_fetch_strobe: assert property (tk && req_kind == EMB_KIND_FETCH |-> ##2 !program_memory_select_n [*2] ##1 program_memory_select_n)
    else $error("program select wrong");
  a_read_strobe: assert property (tk && req_kind == EMB_KIND_READ |-> ##2 !data_read_strobe_n_o [*2] ##1 data_read_strobe_n_o)
    else $error("read strobe wrong");
  a_high_lane: assert property (wt && req_be[1] |-> ##2 !high_byte_write_strobe_n_o [*2])
    else $error("high strobe missing");
  a_low_lane: assert property (wt && req_be[0] |-> ##2 !low_byte_write_strobe_n_o [*2])
    else $error("low strobe missing");
  a_no_lane: assert property (wt && req_be == 2'h0 |=> (high_byte_write_strobe_n_o && low_byte_write_strobe_n_o) [*4])
    else $error("strobe without lane");
  a_pm_exclusive: assert property (!program_memory_select_n |-> data_read_strobe_n_o && high_byte_write_strobe_n_o && low_byte_write_strobe_n_o)
    else $error("two memories selected");
  a_drive_normal: assert property ((data_read_strobe_n_oe == !test_mode) && (high_byte_write_strobe_n_oe == !test_mode) && (low_byte_write_strobe_n_oe == !test_mode))
    else $error("strobe drive wrong");
  a_write_data: assert property (wt |-> ##2 mem_data_oe [*3] ##1 !mem_data_oe)
    else $error("write data not driven");
  a_idle_kind: assert property (tk && req_kind == EMB_KIND_NONE |=> (program_memory_select_n && data_read_strobe_n_o && high_byte_write_strobe_n_o && low_byte_write_strobe_n_o) [*4])
    else $error("strobe on empty access");
  c_fetch: cover property (tk && req_kind == EMB_KIND_FETCH);
  c_read: cover property (tk && req_kind == EMB_KIND_READ);
  c_write: cover property (wt && req_be == 2'h3);
endmodule : emb_external_bus_checker

// File: test/emb_mem_model.sv
// emb_mem_model: external data RAM of 16 words and program memory on the shared bus
// assumes active-low strobes; the released bus shows a value that changes every cycle
`timescale 1ns/100ps
module emb_mem_model
  import emb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic [EMB_ADDR_MSB:EMB_ADDR_LSB] addr,
  input  wire logic                   pm_n,
  input  wire logic                   rd_n,
  input  wire logic                   wrh_n,
  input  wire logic                   wrl_n,
  input  wire logic [EMB_DATA_W-1:0]  wdata,
  input  wire logic                   wdata_oe,
  output logic [EMB_DATA_W-1:0]       rdata
);
  logic [EMB_DATA_W-1:0] ram_reg [16];
  logic [EMB_DATA_W-1:0] last_reg;
  initial begin
    last_reg = 16'h0000;
    for (int i = 0; i < 16; i++) ram_reg[i] = 16'h0000;
  end
  // program or data word onto the bus
  assign rdata = !pm_n ? (addr[16:1] ^ 16'ha5c3) : !rd_n ? ram_reg[addr[4:1]] : ~last_reg;
  always @(posedge clk) last_reg <= rdata;
  // each lane written by its own strobe
  always @(posedge clk) begin
    if (!wrh_n && wdata_oe) ram_reg[addr[4:1]][15:8] <= wdata[15:8];
    if (!wrl_n && wdata_oe) ram_reg[addr[4:1]][7:0] <= wdata[7:0];
  end
endmodule : emb_mem_model

// File: test/emb_external_bus_test.sv
// emb_external_bus_test: drives core requests and test mode, judges pins and answers
// assumes emb_mem_model at the pins; inputs change at the falling edge
`timescale 1ns/100ps
module emb_external_bus_test
  import emb_pkg::*;
;
  logic        clk, srst, req_valid, req_ready, resp_valid, test_mode, pm_n, mem_data_oe;
  logic        rd_o, rd_oe, wrh_o, wrh_oe, wrl_o, wrl_oe;
  emb_kind_t   req_kind;
  logic [19:0] req_addr;
  logic [15:0] req_wdata, resp_rdata, mem_data_o, mem_data_i, rdat;
  logic [1:0]  req_be;
  logic [2:0]  tb_str, test_strobe_seen;
  logic [19:1] mem_addr;
  int          fail_count, total_checks;
  // two-way strobe levels from both drivers
  wire logic rd_w = rd_oe ? rd_o : tb_str[0];
  wire logic wrl_w = wrl_oe ? wrl_o : tb_str[1];
  wire logic wrh_w = wrh_oe ? wrh_o : tb_str[2];
  emb_external_bus dut_u (.clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
    .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .test_mode(test_mode),
    .test_strobe_seen(test_strobe_seen), .mem_addr(mem_addr), .program_memory_select_n(pm_n),
    .data_read_strobe_n_o(rd_o), .data_read_strobe_n_oe(rd_oe), .data_read_strobe_n_i(rd_w),
    .high_byte_write_strobe_n_o(wrh_o), .high_byte_write_strobe_n_oe(wrh_oe),
    .high_byte_write_strobe_n_i(wrh_w), .low_byte_write_strobe_n_o(wrl_o),
    .low_byte_write_strobe_n_oe(wrl_oe), .low_byte_write_strobe_n_i(wrl_w),
    .mem_data_o(mem_data_o), .mem_data_oe(mem_data_oe), .mem_data_i(mem_data_i));
  emb_mem_model mem_u (.clk(clk), .addr(mem_addr), .pm_n(pm_n), .rd_n(rd_w), .wrh_n(wrh_w),
    .wrl_n(wrl_w), .wdata(mem_data_o), .wdata_oe(mem_data_oe), .rdata(mem_data_i));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic final_report();
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  // one access: hold the request until taken, then time the answer
  task automatic access(input emb_kind_t k, input logic [19:0] a, input logic [15:0] d,
                        input logic [1:0] be);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      fail_count++;
      final_report();
    end
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    req_be = be;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    n = 1;
    while (resp_valid !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    check(n, 4);
    rdat = resp_rdata;
  endtask : access
  task automatic reset_check();
    srst = 1'b1;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    check({pm_n, rd_o, wrh_o, wrl_o, resp_valid, mem_data_oe}, 6'h3c);
    check(mem_addr, 19'h0);
    check({test_strobe_seen, resp_rdata}, 19'h0);
  endtask : reset_check
  // lanes, odd address and top address, then read back
  task automatic lanes_check();
    logic [19:0] at [5] = '{20'h00003, 20'h00004, 20'h00006, 20'h00008, 20'hfffff};
    logic [15:0] dt [5] = '{16'h1234, 16'habcd, 16'h5a5a, 16'hffff, 16'hc3c3};
    logic [1:0]  bt [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
    logic [15:0] et [5] = '{16'h1234, 16'hab00, 16'h005a, 16'h0000, 16'hc3c3};
    for (int i = 0; i < 5; i++) access(EMB_KIND_WRITE, at[i], dt[i], bt[i]);
    check(mem_addr, 19'h7ffff);
    for (int i = 0; i < 5; i++) begin
      access(EMB_KIND_READ, at[i] & 20'hffffe, 16'h0000, 2'h0);
      check(rdat, et[i]);
    end
    access(EMB_KIND_FETCH, 20'h12346, 16'h0000, 2'h3);
    check(rdat, 16'h91a3 ^ 16'ha5c3);
  endtask : lanes_check
  // test mode lets the strobe pins be read back
  task automatic test_mode_check();
    test_mode = 1'b1;
    tb_str = 3'h5;
    repeat (2) @(negedge clk);
    check({req_ready, rd_oe, wrh_oe, wrl_oe, test_strobe_seen}, 7'h05);
    tb_str = 3'h6;
    @(negedge clk);
    check(test_strobe_seen, 3'h6);
    test_mode = 1'b0;
    tb_str = 3'h7;
    @(negedge clk);
    check({rd_oe, wrh_oe, wrl_oe, test_strobe_seen}, 6'h3e);
  endtask : test_mode_check
  initial begin
    srst = 1'b1;
    {req_valid, test_mode, req_addr, req_wdata, req_be} = '0;
    req_kind = EMB_KIND_NONE;
    tb_str = 3'h7;
    fail_count = 0;
    total_checks = 0;
    @(negedge clk);
    reset_check();
    lanes_check();
    test_mode_check();
    reset_check();
    access(EMB_KIND_FETCH, 20'h00002, 16'h0000, 2'h0);
    check(rdat, 16'ha5c2);
    access(EMB_KIND_NONE, 20'h00010, 16'h0000, 2'h3);
    check(rdat, 16'ha5c2);
    check(mem_addr, 19'h00008);
    final_report();
  end
endmodule : emb_external_bus_test
bind emb_external_bus emb_external_bus_checker chk_u (
  .clk                         (clk),
  .srst                        (srst),
  .req_valid                   (req_valid),
  .req_ready                   (req_ready),
  .req_kind                    (req_kind),
  .req_addr                    (req_addr),
  .req_be                      (req_be),
  .resp_valid                  (resp_valid),
  .test_mode                   (test_mode),
  .mem_addr                    (mem_addr),
  .program_memory_select_n     (program_memory_select_n),
  .data_read_strobe_n_o        (data_read_strobe_n_o),
  .data_read_strobe_n_oe       (data_read_strobe_n_oe),
  .high_byte_write_strobe_n_o  (high_byte_write_strobe_n_o),
  .high_byte_write_strobe_n_oe (high_byte_write_strobe_n_oe),
  .low_byte_write_strobe_n_o   (low_byte_write_strobe_n_o),
  .low_byte_write_strobe_n_oe  (low_byte_write_strobe_n_oe),
  .mem_data_oe                 (mem_data_oe)
);
